// ===== dv/acs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checker
// ========================================
module acs_monitor (
    input wire logic              SYS_CLK_I,
    input wire logic              RST_N_I,
    input wire logic              CE_I,
    input wire logic              PSEL_I,
    input wire logic              PENABLE_I,
    input wire logic              PWRITE_I,
    input wire logic [7:0]        PADDR_I,
    input wire logic [31:0]       PWDATA_I,
    input wire logic [31:0]       PRDATA_O,
    input wire logic              PREADY_O,
    input wire logic              PSLVERR_O,
    input wire logic              ADC_CMP_I,
    input wire acs_pkg::acs_ana_t ANA_O,
    input wire acs_pkg::acs_ref_t REF_O,
    input wire logic              CONV_TICK_O,
    input wire logic              IRQ_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Shadows of the reference and interrupt enable bits, rebuilt from the bus, and a sampling tick count
    logic [7:0] ref_reg;
    logic       ien_reg;
    logic [2:0] stk_reg;
    wire logic       wr       = CE_I && PSEL_I && PENABLE_I && PWRITE_I;
    wire logic       unm      = PADDR_I[1:0] != 2'h0 || PADDR_I > 8'h14;
    wire logic [3:0] rs       = ref_reg[3:0];
    wire logic       ext      = rs >= 4'h1 && rs <= 4'h4;
    wire logic       bg       = rs >= 4'hA && rs <= 4'hC;
    wire logic [2:0] stk_next = ANA_O.sample ? stk_reg + {2'h0, CONV_TICK_O}
                                             : 3'h0;
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ref_reg <= 8'h00;
            ien_reg <= 1'b0;
            stk_reg <= 3'h0;
        end else begin
            ref_reg <= (wr && PADDR_I == 8'h08) ? PWDATA_I[7:0] : ref_reg;
            ien_reg <= (wr && PADDR_I == 8'h14) ? PWDATA_I[1] : ien_reg;
            stk_reg <= stk_next;
        end
    end
    // ========================================
    // Assertions
    // ========================================
    ready_high_a: assert property (PREADY_O)
        else $error("ready low");
    slverr_map_a: assert property (PSLVERR_O == (PSEL_I && PENABLE_I && unm))
        else $error("slave error wrong");
    rdata_upper_a: assert property (PRDATA_O[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    ref_source_a: assert property (
        REF_O.src == (ext ? acs_pkg::REF_EXT_PIN :
                      bg ? acs_pkg::REF_BANDGAP : acs_pkg::REF_SUPPLY))
        else $error("reference source wrong");
    ref_gain_a: assert property (
        REF_O.amp_bypass == !(ext || bg) &&
        (REF_O.amp_bypass || REF_O.gain_m1 == rs[1:0] - 2'h1))
        else $error("reference gain wrong");
    ref_pins_a: assert property (
        REF_O.out_route == ref_reg[4] && REF_O.in_pin == ref_reg[5])
        else $error("reference pin routing wrong");
    irq_gate_a: assert property (IRQ_O |-> ien_reg)
        else $error("interrupt while disabled");
    power_gate_a: assert property (ANA_O.sample |-> ANA_O.power_en)
        else $error("sampling while unpowered");
    ce_freeze_a: assert property (!CE_I |=> $stable(ANA_O))
        else $error("frozen state moved");
    sample_ticks_a: assert property (
        ANA_O.sample && CONV_TICK_O |-> stk_reg < 3'h4)
        else $error("too many sampling ticks");
    sar_first_a: assert property (
        $fell(ANA_O.sample) && ANA_O.power_en |->
        stk_reg == 3'h4 && ANA_O.dac_code == acs_pkg::SAR_FIRST_TRY)
        else $error("conversion phase opened wrongly");
    rst_vals_a: assert property (
        $rose(RST_N_I) |-> ANA_O == '0 && !IRQ_O && !CONV_TICK_O)
        else $error("outputs not cleared by reset");
    cover property ($fell(ANA_O.sample));
    cover property ($rose(IRQ_O));
    cover property (PSLVERR_O);
endmodule

bind acs_sequencer acs_monitor i_acs_monitor (.*);
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Bench
// ========================================
module tb_top;
    logic              SYS_CLK_I = 1'b0;
    logic              RST_N_I = 1'b0;
    logic              CE_I = 1'b1;
    logic              PSEL_I = 1'b0;
    logic              PENABLE_I = 1'b0;
    logic              PWRITE_I = 1'b0;
    logic [7:0]        PADDR_I = 8'h00;
    logic [31:0]       PWDATA_I = 32'h0000_0000;
    logic              ADC_CMP_I = 1'b0;
    logic [31:0]       PRDATA_O;
    logic              PREADY_O;
    logic              PSLVERR_O;
    acs_pkg::acs_ana_t ANA_O;
    acs_pkg::acs_ref_t REF_O;
    logic              CONV_TICK_O;
    logic              IRQ_O;
    logic [11:0]       target = 12'h000;
    logic [31:0]       rd;
    int                miscompares = 0;
    int                samples_checked = 0;

    always #2 SYS_CLK_I = ~SYS_CLK_I;
    // Ideal comparator facing the trial code
    always @(posedge SYS_CLK_I) ADC_CMP_I <= target >= ANA_O.dac_code;

    acs_sequencer i_acs_sequencer (.*);

    // ========================================
    // Shared tasks
    // ========================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits an edge first: no double drive
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge SYS_CLK_I);
        PSEL_I <= 1'b1;
        PWRITE_I <= wr;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge SYS_CLK_I);
        PENABLE_I <= 1'b1;
        do @(posedge SYS_CLK_I); while (PREADY_O !== 1'b1);
        rd = PRDATA_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask

    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ========================================
    // Scenarios
    // ========================================
    task automatic reset_regs;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            check(rd, 32'h0000_0000);
        end
    endtask

    task automatic start_refused;
        apb(1'b1, 8'h00, 32'h0000_0020);
        apb(1'b1, 8'h00, 32'h0000_0080);
        apb(1'b1, 8'h00, 32'h0000_0000);
        repeat (40) @(posedge SYS_CLK_I);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, 32'h0000_0000);
    endtask

    task automatic ref_codes;
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 8'h08, {26'h0, c[1:0], c[3:0]});
            apb(1'b0, 8'h08, 32'h0000_0000);
            check(rd, {26'h0, c[1:0], c[3:0]});
        end
    endtask

    task automatic convert(input logic [2:0] div, input logic [7:0] al,
                           input logic [11:0] t);
        int n;
        int ticks;
        n = 0;
        ticks = 0;
        target <= t;
        apb(1'b1, 8'h04, {29'h0, div});
        apb(1'b1, 8'h00, {24'h0, 8'hA0 | al});
        repeat (8) @(posedge SYS_CLK_I);
        apb(1'b1, 8'h00, {24'h0, 8'h20 | al});
        #1;
        do begin
            ticks += CONV_TICK_O;
            @(posedge SYS_CLK_I);
            #1;
            n++;
        end while (IRQ_O !== 1'b1 && n < 5000);
        check(n, 32'h0000_0010 << div);
        check(ticks, 32'h0000_0010);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, {24'h0, 8'h20 | al});
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0000_0003);
        apb(1'b1, 8'h14, 32'h0000_0003);
        #1;
        check({31'h0, IRQ_O}, 32'h0000_0000);
    endtask

    task automatic results(input logic [7:0] al, input logic [31:0] hi,
                           input logic [31:0] lo);
        convert(3'h2, al, 12'hA5C);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        check(rd, hi);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check(rd, lo);
    endtask

    // Power drop during sampling must idle and keep the old result
    task automatic power_abort;
        apb(1'b1, 8'h04, 32'h0000_0007);
        apb(1'b1, 8'h00, 32'h0000_00B0);
        apb(1'b1, 8'h00, 32'h0000_0030);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, 32'h0000_0070);
        apb(1'b1, 8'h00, 32'h0000_0010);
        repeat (2200) @(posedge SYS_CLK_I);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0000_0002);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        check(rd, 32'h0000_000A);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check(rd, 32'h0000_005C);
    endtask

    // Interrupt off: poll busy
    task automatic poll_busy;
        int n;
        n = 0;
        target <= 12'h3C7;
        apb(1'b1, 8'h14, 32'h0000_0001);
        apb(1'b1, 8'h04, 32'h0000_0007);
        apb(1'b1, 8'h00, 32'h0000_00A0);
        repeat (8) @(posedge SYS_CLK_I);
        apb(1'b1, 8'h00, 32'h0000_0020);
        CE_I <= 1'b0;
        repeat (20) @(posedge SYS_CLK_I);
        CE_I <= 1'b1;
        do begin
            apb(1'b0, 8'h00, 32'h0000_0000);
            n++;
        end while (rd[6] && n < 1000);
        check(rd, 32'h0000_0020);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        check(rd, 32'h0000_003C);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check(rd, 32'h0000_0070);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check({rd[30:0], IRQ_O}, 32'h0000_0002);
        apb(1'b1, 8'h00, 32'h0000_0000);
    endtask

    initial begin
        repeat (8) @(posedge SYS_CLK_I);
        RST_N_I <= 1'b1;
        reset_regs();
        start_refused();
        ref_codes();
        apb(1'b1, 8'h14, 32'h0000_0002);
        for (int d = 0; d < 8; d++)
            convert(3'(d), 8'h00, 12'h000);
        results(8'h00, 32'h0000_00A5, 32'h0000_00C0);
        results(8'h10, 32'h0000_000A, 32'h0000_005C);
        power_abort();
        poll_busy();
        close_out();
    end

    initial begin
        #200_000;
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire

// ===== src/acs_clk_div.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Conversion clock divider: one tick every 2**div_sel cycles
// ============================================================
module acs_clk_div #(
    parameter int CNT_W = 7
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic             run_i,
    input  wire logic [2:0]       div_sel_i,
    output logic                  tick_o
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] last_cnt;

    // Code 0 gives a tick every cycle, code 7 every 128th
    assign last_cnt = CNT_W'((9'd1 << div_sel_i) - 9'd1);
    assign tick_o   = run_i & (cnt_reg == last_cnt);
    // Stopped counter restarts at zero so every frame has the
    // same phase relative to the start pulse
    assign cnt_next = (!run_i || tick_o) ? '0 : CNT_W'(cnt_reg + 1'b1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
        end
    end

endmodule

`default_nettype wire

// ===== src/acs_pkg.sv
package acs_pkg;

    // ========================================================
    // Register map (byte addresses, one 32-bit word each)
    // ========================================================
    localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
    localparam logic [7:0] ADDR_CTRL_C   = 8'h08;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_RES_LOW  = 8'h10;
    localparam logic [7:0] ADDR_IRQ      = 8'h14;

    // ========================================================
    // Field positions
    // ========================================================
    localparam int CTRL_A_START_BIT = 7;
    localparam int CTRL_A_BUSY_BIT  = 6;
    localparam int CTRL_A_POWER_BIT = 5;
    localparam int CTRL_A_ALIGN_BIT = 4;
    localparam int CTRL_C_REFIN_BIT  = 5;
    localparam int CTRL_C_REFOUT_BIT = 4;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT   = 1;

    // ========================================================
    // Reset values and encodings
    // ========================================================
    localparam logic [2:0]  DIV_SEL_RESET  = 3'h0;
    localparam logic [3:0]  REF_SEL_RESET  = 4'h0;
    localparam logic [3:0]  REF_EXT_FIRST  = 4'h1;
    localparam logic [3:0]  REF_EXT_LAST   = 4'h4;
    localparam logic [3:0]  REF_BG_FIRST   = 4'hA;
    localparam logic [3:0]  REF_BG_LAST    = 4'hC;
    localparam logic [11:0] RESULT_RESET   = 12'h000;
    localparam logic [11:0] SAR_FIRST_TRY  = 12'h800;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

    // ========================================================
    // Timing counts, in conversion clock ticks
    // ========================================================
    localparam logic [3:0] SAMPLE_TICKS = 4'd4;
    localparam logic [3:0] CONVERT_BITS = 4'd12;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b100
    } acs_state_t;

    typedef enum logic [1:0] {
        REF_SUPPLY  = 2'h0,
        REF_EXT_PIN = 2'h1,
        REF_BANDGAP = 2'h2
    } acs_ref_src_t;

    typedef struct packed {
        acs_ref_src_t src;
        logic [1:0]   gain_m1;
        logic         amp_bypass;
        logic         out_route;
        logic         in_pin;
    } acs_ref_t;

    typedef struct packed {
        logic        power_en;
        logic        sample;
        logic [11:0] dac_code;
    } acs_ana_t;

endpackage

// ===== src/acs_sequencer.sv
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Conversion starts only after start bit goes low, high, then low.
// - Busy flag sets once a conversion has been started.
// - Busy flag clears when the conversion completes.
// - Completion sets interrupt flag; interrupt raised only when enabled.
// - Conversion clock is system clock divided by 2**select, 1 to 128.
// - Each conversion opens with exactly 4 conversion clocks of sampling.
// - Then 12 conversion clocks of conversion, 16 in total.
// - Converter is powered only while power enable is high.
// - Four-bit select picks supply, external pin or bandgap reference.
// - Pin reference gets gain 1 to 4, bandgap 2 to 4; supply bypasses it.
// - Selected reference is routed to the reference output pin.
// - Codes 1-4 pin x1..x4, A-C bandgap x2..x4, others supply.
// - Result registers keep their contents while converter is off.
// - Alignment bit places result left or right across two bytes.
module acs_sequencer (
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_N_I,
    input  wire logic              CE_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [7:0]        PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic              ADC_CMP_I,
    output acs_pkg::acs_ana_t      ANA_O,
    output acs_pkg::acs_ref_t      REF_O,
    output logic                   CONV_TICK_O,
    output logic                   IRQ_O
);

    // ========================================================
    // Declarations
    // ========================================================
    logic                 start_reg;
    logic                 busy_reg;
    logic                 power_reg;
    logic                 align_reg;
    logic [2:0]           div_sel_reg;
    logic [3:0]           ref_sel_reg;
    logic                 ref_in_reg;
    logic                 ref_out_reg;
    logic                 irq_flag_reg;
    logic                 irq_en_reg;
    logic [11:0]          result_reg;
    logic [11:0]          result_next;
    logic [31:0]          rdata_reg;
    logic [31:0]          rdata_next;
    acs_pkg::acs_state_t  state_reg;
    acs_pkg::acs_state_t  state_next;
    logic [3:0]           phase_cnt_reg;
    logic [3:0]           phase_cnt_next;
    logic [11:0]          sar_reg;
    logic [11:0]          sar_next;
    logic [3:0]           bit_idx_reg;
    logic [3:0]           bit_idx_next;
    logic                 cmp_meta_reg;
    logic                 cmp_sync_reg;

    logic                 setup_phase;
    logic                 access_phase;
    logic                 wr_en;
    logic                 hit_a;
    logic                 hit_b;
    logic                 hit_c;
    logic                 hit_rh;
    logic                 hit_rl;
    logic                 hit_irq;
    logic                 addr_hit;
    logic                 wr_a;
    logic                 wr_b;
    logic                 wr_c;
    logic                 wr_irq;
    logic                 start_fire;
    logic                 tick;
    logic                 running;
    logic                 sample_done;
    logic                 conv_done;
    logic                 abort;
    logic [11:0]          try_bit;
    logic [11:0]          lower_bit;
    logic [11:0]          decided;
    logic [7:0]           res_high;
    logic [7:0]           res_low;
    logic [7:0]           ctrl_a_rd;
    logic [7:0]           ctrl_b_rd;
    logic [7:0]           ctrl_c_rd;
    logic [7:0]           irq_rd;
    logic                 ref_is_ext;
    logic                 ref_is_bg;
    logic                 irq_set;
    logic                 irq_clr;

    // ========================================================
    // APB decode
    // ========================================================
    assign setup_phase  = PSEL_I & ~PENABLE_I;
    assign access_phase = PSEL_I & PENABLE_I;
    assign hit_a    = (PADDR_I == acs_pkg::ADDR_CTRL_A);
    assign hit_b    = (PADDR_I == acs_pkg::ADDR_CTRL_B);
    assign hit_c    = (PADDR_I == acs_pkg::ADDR_CTRL_C);
    assign hit_rh   = (PADDR_I == acs_pkg::ADDR_RES_HIGH);
    assign hit_rl   = (PADDR_I == acs_pkg::ADDR_RES_LOW);
    assign hit_irq  = (PADDR_I == acs_pkg::ADDR_IRQ);
    assign addr_hit = hit_a | hit_b | hit_c | hit_rh | hit_rl | hit_irq;
    assign wr_en    = access_phase & PWRITE_I;
    assign wr_a     = wr_en & hit_a;
    assign wr_b     = wr_en & hit_b;
    assign wr_c     = wr_en & hit_c;
    assign wr_irq   = wr_en & hit_irq;

    // Zero wait states; read data is captured in the setup cycle
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = access_phase & ~addr_hit;
    assign PRDATA_O  = rdata_reg;

    // ========================================================
    // Start pulse detection
    // ========================================================
    // A write that drops a start bit previously written high
    // completes the low-high-low pulse. Ignored while unpowered.
    assign start_fire = wr_a & start_reg
                      & ~PWDATA_I[acs_pkg::CTRL_A_START_BIT]
                      & power_reg;

    // ========================================================
    // Result formatting
    // ========================================================
    assign res_high = align_reg ? {4'h0, result_reg[11:8]}
                                : result_reg[11:4];
    assign res_low  = align_reg ? result_reg[7:0]
                                : {result_reg[3:0], 4'h0};

    // ========================================================
    // Readback
    // ========================================================
    assign ctrl_a_rd = {start_reg, busy_reg, power_reg, align_reg, 4'h0};
    assign ctrl_b_rd = {5'h00, div_sel_reg};
    assign ctrl_c_rd = {2'h0, ref_in_reg, ref_out_reg, ref_sel_reg};
    assign irq_rd    = {6'h00, irq_en_reg, irq_flag_reg};

    assign rdata_next = !(setup_phase & ~PWRITE_I) ? rdata_reg :
                        hit_a   ? {24'h00_0000, ctrl_a_rd} :
                        hit_b   ? {24'h00_0000, ctrl_b_rd} :
                        hit_c   ? {24'h00_0000, ctrl_c_rd} :
                        hit_rh  ? {24'h00_0000, res_high}  :
                        hit_rl  ? {24'h00_0000, res_low}   :
                        hit_irq ? {24'h00_0000, irq_rd}    :
                                  acs_pkg::RDATA_RESET;

    // ========================================================
    // Reference selection
    // ========================================================
    assign ref_is_ext = (ref_sel_reg >= acs_pkg::REF_EXT_FIRST)
                      & (ref_sel_reg <= acs_pkg::REF_EXT_LAST);
    assign ref_is_bg  = (ref_sel_reg >= acs_pkg::REF_BG_FIRST)
                      & (ref_sel_reg <= acs_pkg::REF_BG_LAST);

    // Reserved code 9 falls through to the supply like any other
    assign REF_O.src = ref_is_ext ? acs_pkg::REF_EXT_PIN :
                       ref_is_bg  ? acs_pkg::REF_BANDGAP :
                                    acs_pkg::REF_SUPPLY;
    // Low two code bits minus one give gain-1 for both ranges
    assign REF_O.gain_m1 = (ref_is_ext | ref_is_bg)
                         ? 2'(ref_sel_reg[1:0] - 2'd1) : 2'd0;
    assign REF_O.amp_bypass = ~(ref_is_ext | ref_is_bg);
    assign REF_O.out_route  = ref_out_reg;
    assign REF_O.in_pin     = ref_in_reg;

    // ========================================================
    // Conversion clock
    // ========================================================
    assign running = (state_reg != acs_pkg::ST_IDLE);

    acs_clk_div #(
        .CNT_W(7)
    ) u_clk_div (
        .clk_i     (SYS_CLK_I),
        .rst_n_i   (RST_N_I),
        .ce_i      (CE_I),
        .run_i     (running),
        .div_sel_i (div_sel_reg),
        .tick_o    (tick)
    );

    assign CONV_TICK_O = tick;

    // ========================================================
    // Sequencer
    // ========================================================
    // Dropping power or raising start again abandons the frame
    assign abort = ~power_reg | start_reg;

    assign sample_done = (state_reg == acs_pkg::ST_SAMPLE) & tick
                       & (phase_cnt_reg == 4'(acs_pkg::SAMPLE_TICKS
                                              - 4'd1));
    assign conv_done   = (state_reg == acs_pkg::ST_CONVERT) & tick
                       & (bit_idx_reg == 4'd0);

    // Successive approximation: keep the trial bit if the input
    // is at or above the trial code, then try the next bit down
    assign try_bit   = 12'(12'h001 << bit_idx_reg);
    assign lower_bit = (bit_idx_reg == 4'd0) ? 12'h000
                                             : 12'(try_bit >> 1);
    assign decided   = cmp_sync_reg ? sar_reg : (sar_reg & ~try_bit);

    always_comb begin
        state_next     = state_reg;
        phase_cnt_next = phase_cnt_reg;
        sar_next       = sar_reg;
        bit_idx_next   = bit_idx_reg;
        case (state_reg)
            acs_pkg::ST_IDLE: begin
                phase_cnt_next = 4'd0;
                if (start_fire) begin
                    state_next = acs_pkg::ST_SAMPLE;
                end
            end
            acs_pkg::ST_SAMPLE: begin
                if (abort) begin
                    state_next = acs_pkg::ST_IDLE;
                end else if (sample_done) begin
                    state_next   = acs_pkg::ST_CONVERT;
                    sar_next     = acs_pkg::SAR_FIRST_TRY;
                    bit_idx_next = 4'(acs_pkg::CONVERT_BITS - 4'd1);
                end else if (tick) begin
                    phase_cnt_next = 4'(phase_cnt_reg + 4'd1);
                end
            end
            acs_pkg::ST_CONVERT: begin
                if (abort) begin
                    state_next = acs_pkg::ST_IDLE;
                end else if (conv_done) begin
                    state_next = acs_pkg::ST_IDLE;
                    sar_next   = decided;
                end else if (tick) begin
                    sar_next     = decided | lower_bit;
                    bit_idx_next = 4'(bit_idx_reg - 4'd1);
                end
            end
            default: begin
                state_next = acs_pkg::ST_IDLE;
            end
        endcase
    end

    // Result only moves on a finished conversion, so it holds
    // while the converter is off
    assign result_next = (conv_done & ~abort) ? decided
                                              : result_reg;

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg     <= acs_pkg::ST_IDLE;
            phase_cnt_reg <= 4'd0;
            sar_reg       <= acs_pkg::RESULT_RESET;
            bit_idx_reg   <= 4'd0;
            result_reg    <= acs_pkg::RESULT_RESET;
        end else if (CE_I) begin
            state_reg     <= state_next;
            phase_cnt_reg <= phase_cnt_next;
            sar_reg       <= sar_next;
            bit_idx_reg   <= bit_idx_next;
            result_reg    <= result_next;
        end
    end

    // ========================================================
    // Busy and interrupt flags
    // ========================================================
    assign irq_set = conv_done & ~abort;
    assign irq_clr = wr_irq & PWDATA_I[acs_pkg::IRQ_FLAG_BIT];

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            busy_reg     <= 1'b0;
            irq_flag_reg <= 1'b0;
        end else if (CE_I) begin
            if (start_fire) begin
                busy_reg <= 1'b1;
            end else if (conv_done | (running & abort)) begin
                busy_reg <= 1'b0;
            end
            // A completion in the clearing cycle is kept
            if (irq_set) begin
                irq_flag_reg <= 1'b1;
            end else if (irq_clr) begin
                irq_flag_reg <= 1'b0;
            end
        end
    end

    assign IRQ_O = irq_flag_reg & irq_en_reg;

    // ========================================================
    // Control registers
    // ========================================================
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            start_reg   <= 1'b0;
            power_reg   <= 1'b0;
            align_reg   <= 1'b0;
            div_sel_reg <= acs_pkg::DIV_SEL_RESET;
            ref_sel_reg <= acs_pkg::REF_SEL_RESET;
            ref_in_reg  <= 1'b0;
            ref_out_reg <= 1'b0;
            irq_en_reg  <= 1'b0;
            rdata_reg   <= acs_pkg::RDATA_RESET;
        end else if (CE_I) begin
            rdata_reg <= rdata_next;
            if (wr_a) begin
                start_reg <= PWDATA_I[acs_pkg::CTRL_A_START_BIT];
                power_reg <= PWDATA_I[acs_pkg::CTRL_A_POWER_BIT];
                align_reg <= PWDATA_I[acs_pkg::CTRL_A_ALIGN_BIT];
            end
            if (wr_b) begin
                div_sel_reg <= PWDATA_I[2:0];
            end
            if (wr_c) begin
                ref_sel_reg <= PWDATA_I[3:0];
                ref_in_reg  <= PWDATA_I[acs_pkg::CTRL_C_REFIN_BIT];
                ref_out_reg <= PWDATA_I[acs_pkg::CTRL_C_REFOUT_BIT];
            end
            if (wr_irq) begin
                irq_en_reg <= PWDATA_I[acs_pkg::IRQ_EN_BIT];
            end
        end
    end

    // ========================================================
    // Comparator synchroniser and analog controls
    // ========================================================
    // The two-stage delay means each bit decision sees the
    // comparator two cycles late; divide codes below 2 give
    // less settling than that and degrade accuracy.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end else if (CE_I) begin
            cmp_meta_reg <= ADC_CMP_I;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    assign ANA_O.power_en = power_reg;
    assign ANA_O.sample   = (state_reg == acs_pkg::ST_SAMPLE) & power_reg;
    assign ANA_O.dac_code = sar_reg;

endmodule

`default_nettype wire
